// [src/extreme_pkg.sv]
package extreme_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_MIN_PH_HI  = 8'h1C;
	localparam logic [7:0] ADDR_MIN_PH_MID = 8'h1D;
	localparam logic [7:0] ADDR_MIN_PH_LO  = 8'h1E;
	localparam logic [7:0] ADDR_MIN_T_HI   = 8'h1F;
	localparam logic [7:0] ADDR_MIN_T_LO   = 8'h20;
	localparam logic [7:0] ADDR_MAX_PH_HI  = 8'h21;
	localparam logic [7:0] ADDR_MAX_PH_MID = 8'h22;
	localparam logic [7:0] ADDR_MAX_PH_LO  = 8'h23;
	localparam logic [7:0] ADDR_MAX_T_HI   = 8'h24;
	localparam logic [7:0] ADDR_MAX_T_LO   = 8'h25;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int         PH_WIDTH     = 20;
	localparam int         TEMP_WIDTH   = 12;
	localparam logic [7:0] LO_WRITE_MASK = 8'hF0;
	localparam logic [7:0] BYTE_RESET   = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage : extreme_pkg

// [src/extreme_tracker.sv]
`timescale 1ns/1ps

// Holds one extreme value; updates on strictly better sample, loads host bytes
module extreme_tracker #(
	parameter int  WIDTH    = 20,
	parameter bit  KEEP_MAX = 1'b0
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	// Sample
	input  wire logic             i_sample_valid,
	input  wire logic [WIDTH-1:0] i_sample,
	input  wire logic             i_signed,
	// Host byte writes, already masked and merged
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_load_value,
	// Stored value
	output logic      [WIDTH-1:0] o_value
);

	logic             empty;
	logic             better;
	logic [WIDTH-1:0] a_key;
	logic [WIDTH-1:0] b_key;

	// Flip sign bit so one unsigned compare serves both encodings
	always_comb
	begin
		a_key = i_sample ^ {i_signed, {(WIDTH-1){1'b0}}};
		b_key = o_value ^ {i_signed, {(WIDTH-1){1'b0}}};
		better = KEEP_MAX ? (a_key > b_key) : (a_key < b_key); // Ties keep old value
	end

	// After a clear the first sample is taken as-is, so tracking restarts
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_value <= '0;
			empty   <= 1'b1;
		end
		else if (i_load)
		begin
			o_value <= i_load_value;
			empty   <= (i_load_value == '0);
		end
		else if (i_sample_valid && (empty || better))
		begin
			o_value <= i_sample;
			empty   <= 1'b0;
		end
	end

endmodule : extreme_tracker

// [src/min_max_capture_regs.sv]
`timescale 1ns/1ps

// Operation
// - The lowest pressure or height result since the last clear is kept in its own byte group.
// - The highest pressure or height result since the last clear is kept in another byte group.
// - In height mode the extreme is 20-bit signed metres, 16 integer bits high/mid, 4 fraction bits at lo[7:4].
// - In pressure mode the extreme is 20-bit unsigned pascals, 18 integer bits to lo[7:6].
// - In pressure mode the two fraction bits sit at lo[5:4].
// - The lowest temperature since the last clear is kept in a two-byte group.
// - The highest temperature since the last clear is kept in another two-byte group.
// - Temperature extremes are 12-bit signed degrees with the integer in the high byte.
// - The four fractional degree bits sit at lo[7:4].
// - All groups reset to zero and a host write that leaves a group's whole value zero clears it and restarts tracking.
// - Mode bit zero (reset) means pressure, one means height.
module min_max_capture_regs #(
	parameter int PH_W = extreme_pkg::PH_WIDTH,
	parameter int T_W  = extreme_pkg::TEMP_WIDTH
) (
	// Clock and reset
	input  wire logic            i_clock,
	input  wire logic            i_rst_n,
	// Measurement engine results
	input  wire logic            i_result_valid,
	input  wire logic [PH_W-1:0] i_pressure_height,
	input  wire logic [T_W-1:0]  i_temperature,
	input  wire logic            i_height_mode_select,
	// Register port from serial interface
	input  wire logic            i_reg_write,
	input  wire logic            i_reg_read,
	input  wire logic [7:0]      i_reg_addr,
	input  wire logic [7:0]      i_reg_wdata,
	output logic      [7:0]      o_reg_rdata
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta;
	logic rst_sync_n;

	// Async assert, synchronous release
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ****************************************
	// Trackers
	// ****************************************
	logic [PH_W-1:0] min_ph;
	logic [PH_W-1:0] max_ph;
	logic [T_W-1:0]  min_t;
	logic [T_W-1:0]  max_t;
	logic            load_min_ph;
	logic            load_max_ph;
	logic            load_min_t;
	logic            load_max_t;
	logic [PH_W-1:0] next_min_ph;
	logic [PH_W-1:0] next_max_ph;
	logic [T_W-1:0]  next_min_t;
	logic [T_W-1:0]  next_max_t;
	logic [7:0]      wlo;

	// Low byte keeps only bits 7:4; bits 3:0 are not stored
	assign wlo = i_reg_wdata & extreme_pkg::LO_WRITE_MASK;

	// Writes merge one byte into the stored value
	always_comb
	begin
		next_min_ph = min_ph;
		next_max_ph = max_ph;
		next_min_t  = min_t;
		next_max_t  = max_t;
		load_min_ph = 1'b0;
		load_max_ph = 1'b0;
		load_min_t  = 1'b0;
		load_max_t  = 1'b0;
		if (i_reg_write)
		begin
			case (i_reg_addr)
				extreme_pkg::ADDR_MIN_PH_HI:
				begin
					next_min_ph[19:12] = i_reg_wdata;
					load_min_ph        = 1'b1;
				end
				extreme_pkg::ADDR_MIN_PH_MID:
				begin
					next_min_ph[11:4] = i_reg_wdata;
					load_min_ph       = 1'b1;
				end
				extreme_pkg::ADDR_MIN_PH_LO:
				begin
					next_min_ph[3:0] = wlo[7:4];
					load_min_ph      = 1'b1;
				end
				extreme_pkg::ADDR_MIN_T_HI:
				begin
					next_min_t[11:4] = i_reg_wdata;
					load_min_t       = 1'b1;
				end
				extreme_pkg::ADDR_MIN_T_LO:
				begin
					next_min_t[3:0] = wlo[7:4];
					load_min_t      = 1'b1;
				end
				extreme_pkg::ADDR_MAX_PH_HI:
				begin
					next_max_ph[19:12] = i_reg_wdata;
					load_max_ph        = 1'b1;
				end
				extreme_pkg::ADDR_MAX_PH_MID:
				begin
					next_max_ph[11:4] = i_reg_wdata;
					load_max_ph       = 1'b1;
				end
				extreme_pkg::ADDR_MAX_PH_LO:
				begin
					next_max_ph[3:0] = wlo[7:4];
					load_max_ph      = 1'b1;
				end
				extreme_pkg::ADDR_MAX_T_HI:
				begin
					next_max_t[11:4] = i_reg_wdata;
					load_max_t       = 1'b1;
				end
				extreme_pkg::ADDR_MAX_T_LO:
				begin
					next_max_t[3:0] = wlo[7:4];
					load_max_t      = 1'b1;
				end
				default:
				begin
					load_min_ph = 1'b0;
				end
			endcase
		end
	end

	// Pressure groups: signed compare in height mode, unsigned in pressure
	extreme_tracker #(.WIDTH(PH_W), .KEEP_MAX(1'b0)) u_min_ph (
		.i_clock        (i_clock),
		.i_rst_n        (rst_sync_n),
		.i_sample_valid (i_result_valid),
		.i_sample       (i_pressure_height),
		.i_signed       (i_height_mode_select),
		.i_load         (load_min_ph),
		.i_load_value   (next_min_ph),
		.o_value        (min_ph)
	);

	extreme_tracker #(.WIDTH(PH_W), .KEEP_MAX(1'b1)) u_max_ph (
		.i_clock        (i_clock),
		.i_rst_n        (rst_sync_n),
		.i_sample_valid (i_result_valid),
		.i_sample       (i_pressure_height),
		.i_signed       (i_height_mode_select),
		.i_load         (load_max_ph),
		.i_load_value   (next_max_ph),
		.o_value        (max_ph)
	);

	// Temperature groups are always two's complement
	extreme_tracker #(.WIDTH(T_W), .KEEP_MAX(1'b0)) u_min_t (
		.i_clock        (i_clock),
		.i_rst_n        (rst_sync_n),
		.i_sample_valid (i_result_valid),
		.i_sample       (i_temperature),
		.i_signed       (1'b1),
		.i_load         (load_min_t),
		.i_load_value   (next_min_t),
		.o_value        (min_t)
	);

	extreme_tracker #(.WIDTH(T_W), .KEEP_MAX(1'b1)) u_max_t (
		.i_clock        (i_clock),
		.i_rst_n        (rst_sync_n),
		.i_sample_valid (i_result_valid),
		.i_sample       (i_temperature),
		.i_signed       (1'b1),
		.i_load         (load_max_t),
		.i_load_value   (next_max_t),
		.o_value        (max_t)
	);

	// ****************************************
	// Read path
	// ****************************************
	logic [7:0] next_rdata;

	// Bit positions are identical in both modes; only the meaning differs
	always_comb
	begin
		case (i_reg_addr)
			extreme_pkg::ADDR_MIN_PH_HI:  next_rdata = min_ph[19:12];
			extreme_pkg::ADDR_MIN_PH_MID: next_rdata = min_ph[11:4];
			extreme_pkg::ADDR_MIN_PH_LO:  next_rdata = {min_ph[3:0], 4'h0};
			extreme_pkg::ADDR_MIN_T_HI:   next_rdata = min_t[11:4];
			extreme_pkg::ADDR_MIN_T_LO:   next_rdata = {min_t[3:0], 4'h0};
			extreme_pkg::ADDR_MAX_PH_HI:  next_rdata = max_ph[19:12];
			extreme_pkg::ADDR_MAX_PH_MID: next_rdata = max_ph[11:4];
			extreme_pkg::ADDR_MAX_PH_LO:  next_rdata = {max_ph[3:0], 4'h0};
			extreme_pkg::ADDR_MAX_T_HI:   next_rdata = max_t[11:4];
			extreme_pkg::ADDR_MAX_T_LO:   next_rdata = {max_t[3:0], 4'h0};
			default:                      next_rdata = extreme_pkg::READ_UNMAPPED;
		endcase
	end

	// Registered read data, held between reads
	always_ff @(posedge i_clock or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			o_reg_rdata <= extreme_pkg::BYTE_RESET;
		else if (i_reg_read)
			o_reg_rdata <= next_rdata;
	end

endmodule : min_max_capture_regs

// [testbench/reg_host_model.sv]
`timescale 1ns/1ps

// ****************
// Host on the register port
// ****************
module reg_host_model (
	// Clock
	input  wire logic       i_clock,
	// Register port
	output logic            o_write,
	output logic            o_read,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	input  wire logic [7:0] i_rdata
);
	// Idle port at time zero
	initial
	begin
		o_write = 1'h0;
		o_read  = 1'h0;
		o_addr  = 8'h00;
		o_wdata = 8'h00;
	end

	// Back-to-back writes leave a gap so the strobe is never set twice at one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (o_write)
			@(posedge i_clock);
		o_write <= 1'h1;
		o_addr  <= a;
		o_wdata <= d;
		@(posedge i_clock);
		o_write <= 1'h0;
		o_wdata <= ~d; // Released data must not look valid
	endtask : wr

	// Read data stands until the next read, so it is taken one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		o_read <= 1'h1;
		o_addr <= a;
		@(posedge i_clock);
		o_read <= 1'h0;
		@(posedge i_clock);
		d = i_rdata;
	endtask : rd
endmodule : reg_host_model

// [testbench/min_max_capture_regs_props.sv]
`timescale 1ns/1ps

// ****************
// Port checks
// ****************
module extreme_checker #(
	parameter int PH_W = 20,
	parameter int T_W  = 12
) (
	// Watched ports
	input wire logic            i_clock,
	input wire logic            i_rst_n,
	input wire logic            i_result_valid,
	input wire logic [PH_W-1:0] i_pressure_height,
	input wire logic [T_W-1:0]  i_temperature,
	input wire logic            i_height_mode_select,
	input wire logic            i_reg_write,
	input wire logic            i_reg_read,
	input wire logic [7:0]      i_reg_addr,
	input wire logic [7:0]      i_reg_wdata,
	input wire logic [7:0]      o_reg_rdata
);
	logic mapped;
	logic is_lo;

	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	// Address decode
	assign mapped = i_reg_addr >= 8'h1C && i_reg_addr <= 8'h25;
	assign is_lo  = i_reg_addr inside {8'h1E, 8'h20, 8'h23, 8'h25};

	// Write then read of the same byte with nothing in between
	sequence s_wr_rd;
		i_reg_write && mapped ##1 i_reg_read && !i_reg_write && !i_result_valid
			&& $stable(i_reg_addr);
	endsequence

	// Host seeds an extreme, one idle cycle, then reads it
	sequence s_keep(a, d, m);
		i_reg_write && i_reg_addr == a && i_reg_wdata == d && m ##1 !i_reg_write && m
			##1 i_reg_read && !i_reg_write && i_reg_addr == a && m;
	endsequence

	a_reset_clears: assert property ($rose(i_rst_n) |-> o_reg_rdata == 8'h00)
		else $error("read data not zero after reset");
	a_lo_nibble_zero: assert property (i_reg_read && is_lo |=> o_reg_rdata[3:0] == 4'h0)
		else $error("low nibble not zero");
	a_hi_readback: assert property (s_wr_rd ##0 !is_lo |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("written byte not read back");
	a_lo_readback: assert property (s_wr_rd ##0 is_lo |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'hF0))
		else $error("low byte write not masked");
	a_tmax_keeps: assert property (s_keep(8'h24, 8'h7F, 1'h1) |=> o_reg_rdata == 8'h7F)
		else $error("top temperature replaced");
	a_tmin_keeps: assert property (s_keep(8'h1F, 8'h80, 1'h1) |=> o_reg_rdata == 8'h80)
		else $error("bottom temperature replaced");
	a_pmax_keeps: assert property (s_keep(8'h21, 8'hFF, !i_height_mode_select) |=> o_reg_rdata == 8'hFF)
		else $error("top pressure replaced");
	a_pmin_keeps: assert property (s_keep(8'h1C, 8'h80, i_height_mode_select) |=> o_reg_rdata == 8'h80)
		else $error("bottom height replaced");
endmodule : extreme_checker

bind min_max_capture_regs extreme_checker #(.PH_W(PH_W), .T_W(T_W)) i_chk (
	.i_clock, .i_rst_n, .i_result_valid, .i_pressure_height, .i_temperature,
	.i_height_mode_select, .i_reg_write, .i_reg_read, .i_reg_addr, .i_reg_wdata, .o_reg_rdata
);

// [testbench/min_max_capture_regs_tb.sv]
`timescale 1ns/1ps

// ****************
// Bench
// ****************
module min_max_capture_regs_tb;
	logic        clock;
	logic        rst_n;
	logic        res_valid;
	logic [19:0] ph;
	logic [11:0] temp;
	logic        mode;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	int          n_mismatch = 0;
	int          compares   = 0;

	// 200 MHz clock
	initial
	begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end

	min_max_capture_regs i_dut (.i_clock(clock), .i_rst_n(rst_n), .i_result_valid(res_valid),
		.i_pressure_height(ph), .i_temperature(temp), .i_height_mode_select(mode),
		.i_reg_write(wr_en), .i_reg_read(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata));
	reg_host_model i_host (.i_clock(clock), .o_write(wr_en), .o_read(rd_en), .o_addr(addr),
		.o_wdata(wdata), .i_rdata(rdata));

	task automatic chk(input logic [7:0] a, input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected byte at %h: expected %h seen %h", a, exp, got);
		end
	endtask : chk

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.rd(a, d);
		chk(a, d, e);
	endtask : rc

	// One result pair; data is scrambled once the pulse is over
	task automatic res(input logic [19:0] p, input logic [11:0] t);
		if (res_valid)
			@(posedge clock);
		res_valid <= 1'h1;
		ph        <= p;
		temp      <= t;
		@(posedge clock);
		res_valid <= 1'h0;
		ph        <= ~p;
		temp      <= ~t;
	endtask : res

	task automatic t_reset();
		for (int a = 8'h1C; a <= 8'h25; a++)
			rc(8'(a), 8'h00);
	endtask : t_reset

	task automatic t_pressure();
		res(20'hABCDE, 12'h7F3);
		res(20'h12345, 12'h805);
		res(20'hFFFFF, 12'h100);
		rc(8'h1C, 8'h12);
		rc(8'h1D, 8'h34);
		rc(8'h1E, 8'h50);
		rc(8'h21, 8'hFF);
		rc(8'h23, 8'hF0);
		rc(8'h1F, 8'h80);
		rc(8'h20, 8'h50);
		rc(8'h24, 8'h7F);
		rc(8'h25, 8'h30);
	endtask : t_pressure

	task automatic t_keep();
		i_host.wr(8'h24, 8'h7F);
		res(20'hFFFFF, 12'h7FF);
		rc(8'h24, 8'h7F);
		rc(8'h25, 8'hF0);
		i_host.wr(8'h1F, 8'h80);
		res(20'hFFFFF, 12'h800);
		rc(8'h1F, 8'h80);
		rc(8'h20, 8'h00);
		i_host.wr(8'h21, 8'hFF);
		res(20'hFFFFF, 12'h000);
		rc(8'h21, 8'hFF);
		i_host.wr(8'h1D, 8'h5A);
		rc(8'h1D, 8'h5A);
		i_host.wr(8'h1E, 8'hFF);
		rc(8'h1E, 8'hF0);
		i_host.wr(8'h30, 8'hAA);
		rc(8'h30, 8'h00);
	endtask : t_keep

	// Signed order in height mode reverses the pressure-mode outcome
	task automatic t_height();
		for (int a = 8'h1C; a <= 8'h25; a++)
			i_host.wr(8'(a), 8'h00);
		mode <= 1'h1;
		res(20'h00010, 12'h000);
		res(20'hFFFF0, 12'h000);
		rc(8'h1C, 8'hFF);
		rc(8'h1E, 8'h00);
		rc(8'h22, 8'h01);
		i_host.wr(8'h1C, 8'h80);
		res(20'h00010, 12'h000);
		rc(8'h1C, 8'h80);
	endtask : t_height

	// A reset in mid-run must wipe groups that now hold non-zero extremes
	task automatic t_rerun_reset();
		rst_n <= 1'h0;
		repeat (6) @(posedge clock);
		rst_n <= 1'h1;
		repeat (3) @(posedge clock);
		t_reset();
	endtask : t_rerun_reset

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// Watchdog: tests need under 150 cycles, this allows 4000
	initial
	begin
		#20000;
		n_mismatch++;
		finish_test();
	end

	// Reset for 6 cycles, first request at the third edge after release
	initial
	begin
		rst_n     = 1'h0;
		res_valid = 1'h0;
		ph        = 20'h00000;
		temp      = 12'h000;
		mode      = 1'h0;
		repeat (6) @(posedge clock);
		rst_n <= 1'h1;
		repeat (3) @(posedge clock);
		t_reset();
		t_pressure();
		t_keep();
		t_height();
		t_rerun_reset();
		finish_test();
	end
endmodule : min_max_capture_regs_tb
